// ===== verilog/switch_scan_pkg.sv
package switch_scan_pkg;

  // register indices on the serial register port
  localparam logic [5:0] ADDR_CONFIG    = 6'h1a;
  localparam logic [5:0] ADDR_IN_ENABLE = 6'h1b;
  localparam logic [5:0] ADDR_CUR_DIR   = 6'h1c;

  // field positions in the main configuration register
  localparam int RESET_BIT     = 0;
  localparam int POLL_TIME_LSB = 1;
  localparam int POLL_EN_BIT   = 10;
  localparam int RUN_BIT       = 11;

  // widths and reset values
  localparam int REG_W       = 24;
  localparam int NUM_INPUTS  = 24;
  localparam int DIR_INPUTS  = 10;
  localparam int PERIOD_W    = 13;
  localparam logic [23:0] CONFIG_RESET   = 24'h00_0000;
  localparam logic [23:0] ENABLE_RESET   = 24'h00_0000;
  localparam logic [23:0] CUR_DIR_RESET  = 24'h00_0000;
  localparam logic [23:0] CUR_DIR_RW     = 24'h00_03ff;
  localparam logic [3:0]  POLL_CODE_MAX  = 4'hc;
  localparam logic [12:0] POLL_FALLBACK  = 13'h0008;

  // timing: one millisecond expressed in core clock cycles
  localparam int CLK_PERIOD_NS = 20;
  localparam int MS_NS         = 1000000;
  localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;

  // one access from the serial frame decoder
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [5:0]  addr;
    logic [23:0] wdata;
  } reg_req_type;

  typedef enum logic [1:0] {
    SCAN_IDLE = 2'b00,
    SCAN_WAIT = 2'b01,
    SCAN_STEP = 2'b10
  } scan_state_type;

endpackage

// ===== verilog/switch_scan_config_regs.sv
`timescale 1ns/100ps
// Operation
// R1 - poll code 0..C gives 2..4096 ms; codes above C give 8 ms.
// R2 - writing one to config bit 0 starts a whole-device software reset.
// R3 - one enable bit per input 0..23; polling skips inputs with zero.
// R4 - only inputs with enable one are monitored and polled.
// R5 - direction bit zero selects current source, one selects current sink, inputs 0..9.
// R6 - input enable register resets to zero, all inputs disabled.
// R7 - direction register resets to zero; bits 23..10 reserved, read zero.
// R8 - controller stops run bit before reconfiguring, then restarts it.
// R9 - poll-enable zero runs continuous; one runs polling at the chosen period.
// R10 - software reset returns all configuration, reset bit included, to reset values.
module switch_scan_config_regs #(
  parameter int ms_cycles = switch_scan_pkg::MS_CYCLES
) (
  // clock and reset
  input  wire logic                        core_clk,
  input  wire logic                        srst,
  // register port from the serial frame decoder
  input  wire switch_scan_pkg::reg_req_type reg_req,
  output logic [23:0]                       reg_rdata,
  // device control outputs
  output logic                              soft_reset_pulse,
  output logic [23:0]                       channel_monitor_en,
  output logic [9:0]                        current_direction_bit,
  output logic [12:0]                       poll_period_ms,
  output logic                              poll_mode,
  // scan sequence
  output logic                              scan_valid,
  output logic [4:0]                        scan_channel
);

  // poll code to period in milliseconds
  function automatic logic [12:0] poll_decode(input logic [3:0] code);
    logic [12:0] ms;
    ms = switch_scan_pkg::POLL_FALLBACK;
    if (code <= switch_scan_pkg::POLL_CODE_MAX) begin
      unique case (code)
        4'h5:    ms = 13'h0030;
        default: ms = 13'(13'h0002 << (code - ((code > 4'h5) ? 4'h1 : 4'h0)));
      endcase
    end
    return ms; // R1
  endfunction

  logic [23:0]  config_reg;
  logic [23:0]  in_enable;
  logic [23:0]  cur_dir;
  logic         reset_pending;
  logic [23:0]  next_config_reg;
  logic [23:0]  next_in_enable;
  logic [23:0]  next_cur_dir;
  logic         next_reset_pending;
  logic [23:0]  next_rdata;
  logic [12:0]  next_period;
  logic         run;
  logic         poll_en;

  assign run     = config_reg[switch_scan_pkg::RUN_BIT];
  assign poll_en = config_reg[switch_scan_pkg::POLL_EN_BIT];

  // register writes, software reset and readback
  always_comb begin
    next_config_reg    = config_reg;
    next_in_enable     = in_enable;
    next_cur_dir       = cur_dir;
    next_reset_pending = 1'b0;
    next_rdata         = 24'h00_0000;
    if (reset_pending) begin
      next_config_reg = switch_scan_pkg::CONFIG_RESET; // R10
      next_in_enable  = switch_scan_pkg::ENABLE_RESET; // R10
      next_cur_dir    = switch_scan_pkg::CUR_DIR_RESET; // R10
    end else if (reg_req.wr) begin
      unique case (reg_req.addr)
        switch_scan_pkg::ADDR_CONFIG: begin
          next_config_reg    = reg_req.wdata & 24'hff_fffe;
          next_reset_pending = reg_req.wdata[switch_scan_pkg::RESET_BIT]; // R2
        end
        switch_scan_pkg::ADDR_IN_ENABLE: next_in_enable = reg_req.wdata; // R3
        switch_scan_pkg::ADDR_CUR_DIR:   next_cur_dir = reg_req.wdata & switch_scan_pkg::CUR_DIR_RW; // R7
        default: ;
      endcase
    end
    if (reg_req.rd) begin
      unique case (reg_req.addr)
        switch_scan_pkg::ADDR_CONFIG:    next_rdata = config_reg | 24'(reset_pending);
        switch_scan_pkg::ADDR_IN_ENABLE: next_rdata = in_enable;
        switch_scan_pkg::ADDR_CUR_DIR:   next_rdata = cur_dir;
        default:                         next_rdata = 24'h00_0000;
      endcase
    end
    next_period = poll_decode(config_reg[switch_scan_pkg::POLL_TIME_LSB +: 4]); // R1
  end

  // register state
  always_ff @(posedge core_clk) begin
    if (srst) begin
      config_reg       <= switch_scan_pkg::CONFIG_RESET;
      in_enable        <= switch_scan_pkg::ENABLE_RESET; // R6
      cur_dir          <= switch_scan_pkg::CUR_DIR_RESET; // R7
      reset_pending    <= 1'b0;
      reg_rdata        <= 24'h00_0000;
      poll_period_ms   <= 13'h0002;
    end else begin
      config_reg       <= next_config_reg;
      in_enable        <= next_in_enable;
      cur_dir          <= next_cur_dir;
      reset_pending    <= next_reset_pending;
      reg_rdata        <= next_rdata;
      poll_period_ms   <= next_period;
    end
  end

  // control outputs straight from the registers
  assign soft_reset_pulse      = reset_pending; // R2
  assign channel_monitor_en    = in_enable; // R4
  assign current_direction_bit = cur_dir[9:0]; // R5
  assign poll_mode             = poll_en; // R9

  switch_scan_pkg::scan_state_type state;
  switch_scan_pkg::scan_state_type next_state;
  logic [15:0] pre_cnt;
  logic [12:0] ms_cnt;
  logic [4:0]  idx;
  logic [15:0] next_pre_cnt;
  logic [12:0] next_ms_cnt;
  logic [4:0]  next_idx;
  logic        next_scan_valid;
  logic [4:0]  next_scan_channel;
  logic        ms_tick;
  logic        period_tick;

  assign ms_tick     = (pre_cnt == 16'(ms_cycles - 1));
  assign period_tick = ms_tick && (ms_cnt == 13'(poll_period_ms - 13'h0001));

  // scan sequencer: continuous sweeps or one sweep per poll period
  always_comb begin
    next_state        = state;
    next_pre_cnt      = 16'h0000;
    next_ms_cnt       = 13'h0000;
    next_idx          = idx;
    next_scan_valid   = 1'b0;
    next_scan_channel = scan_channel;
    unique case (state)
      switch_scan_pkg::SCAN_IDLE: begin
        next_idx = 5'h00;
        if (run) begin
          next_state = poll_en ? switch_scan_pkg::SCAN_WAIT : switch_scan_pkg::SCAN_STEP; // R9
        end
      end
      switch_scan_pkg::SCAN_WAIT: begin
        if (!run) begin
          next_state = switch_scan_pkg::SCAN_IDLE; // R8
        end else if (period_tick) begin
          next_state = switch_scan_pkg::SCAN_STEP; // R9
        end else begin
          next_pre_cnt = ms_tick ? 16'h0000 : 16'(pre_cnt + 16'h0001);
          next_ms_cnt  = ms_tick ? 13'(ms_cnt + 13'h0001) : ms_cnt;
        end
      end
      switch_scan_pkg::SCAN_STEP: begin
        if (!run) begin
          next_state = switch_scan_pkg::SCAN_IDLE; // R8
        end else begin
          next_scan_valid   = in_enable[idx]; // R3 R4
          next_scan_channel = idx;
          if (idx == 5'(switch_scan_pkg::NUM_INPUTS - 1)) begin
            next_idx = 5'h00;
            if (poll_en) begin
              next_state = switch_scan_pkg::SCAN_WAIT; // R9
            end
          end else begin
            next_idx = 5'(idx + 5'h01);
          end
        end
      end
      default: next_state = switch_scan_pkg::SCAN_IDLE;
    endcase
  end

  // sequencer state
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state        <= switch_scan_pkg::SCAN_IDLE;
      pre_cnt      <= 16'h0000;
      ms_cnt       <= 13'h0000;
      idx          <= 5'h00;
      scan_valid   <= 1'b0;
      scan_channel <= 5'h00;
    end else begin
      state        <= next_state;
      pre_cnt      <= next_pre_cnt;
      ms_cnt       <= next_ms_cnt;
      idx          <= next_idx;
      scan_valid   <= next_scan_valid;
      scan_channel <= next_scan_channel;
    end
  end

  // checks
  poll_fallback_a: assert property (@(posedge core_clk) disable iff (srst) // R1
    config_reg[4:1] > 4'hc |=> poll_period_ms == 13'h0008)
    else $error("poll code above C did not give 8 ms");
  poll_table_a: assert property (@(posedge core_clk) disable iff (srst) // R1
    config_reg[4:1] == 4'h5 |=> poll_period_ms == 13'h0030)
    else $error("poll code 5 did not give 48 ms");
  soft_reset_a: assert property (@(posedge core_clk) disable iff (srst) // R2
    reg_req.wr && reg_req.addr == 6'h1a && reg_req.wdata[0] && !reset_pending
    |=> soft_reset_pulse ##1 (config_reg == 24'h00_0000 && in_enable == 24'h00_0000))
    else $error("software reset did not clear configuration");
  reset_clear_a: assert property (@(posedge core_clk) disable iff (srst) // R10
    soft_reset_pulse |=> !soft_reset_pulse && cur_dir == 24'h00_0000)
    else $error("reset bit or direction not cleared");
  skip_disabled_a: assert property (@(posedge core_clk) disable iff (srst) // R3
    state == switch_scan_pkg::SCAN_STEP && run && !in_enable[idx] |=> !scan_valid)
    else $error("disabled input was scanned");
  por_values_a: assert property (@(posedge core_clk) // R6
    $past(srst) |-> in_enable == 24'h00_0000 && cur_dir == 24'h00_0000)
    else $error("reset value wrong");
  reserved_dir_a: assert property (@(posedge core_clk) disable iff (srst) // R7
    reg_req.rd && reg_req.addr == 6'h1c |=> reg_rdata[23:10] == 14'h0000)
    else $error("reserved direction bits read nonzero");
  dir_follow_a: assert property (@(posedge core_clk) disable iff (srst) // R5
    reg_req.wr && reg_req.addr == 6'h1c && !reset_pending
    |=> current_direction_bit == $past(reg_req.wdata[9:0]))
    else $error("direction bits did not follow write");
  continuous_a: assert property (@(posedge core_clk) disable iff (srst) // R9
    state == switch_scan_pkg::SCAN_IDLE && run && !poll_en
    |=> state == switch_scan_pkg::SCAN_STEP)
    else $error("continuous mode did not start scanning");
  stop_a: assert property (@(posedge core_clk) disable iff (srst) // R8
    !run && state != switch_scan_pkg::SCAN_IDLE |=> state == switch_scan_pkg::SCAN_IDLE)
    else $error("sequencer ignored run stop");

  poll_wakeup_c: cover property (@(posedge core_clk) disable iff (srst)
    state == switch_scan_pkg::SCAN_WAIT ##1 state == switch_scan_pkg::SCAN_STEP);
  soft_reset_c: cover property (@(posedge core_clk) disable iff (srst) soft_reset_pulse);
  scan_hit_c: cover property (@(posedge core_clk) disable iff (srst)
    scan_valid && scan_channel == 5'h17);

endmodule // switch_scan_config_regs

// ===== sim/reg_commander.sv
`timescale 1ns/100ps
// commander model: one register access per call
module reg_commander (
  // clock
  input  wire logic                          core_clk,
  // register request toward the bank
  output switch_scan_pkg::reg_req_type       reg_req
);
  initial reg_req = '0;

  // request held across one taking edge, then strobes dropped and data scrambled
  task automatic access(input logic wr, input logic rd, input logic [5:0] addr,
                        input logic [23:0] data);
    @(posedge core_clk);
    reg_req <= '{wr: wr, rd: rd, addr: addr, wdata: data};
    @(posedge core_clk);
    reg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~data};
  endtask
endmodule // reg_commander

// ===== sim/testbench.sv
`timescale 1ns/100ps
// self-checking bench for the configuration register bank
module testbench;
  logic                         core_clk;
  logic                         srst;
  switch_scan_pkg::reg_req_type reg_req;
  logic [23:0]                  reg_rdata;
  logic [23:0]                  channel_monitor_en;
  logic [23:0]                  en;
  logic [23:0]                  dir;
  logic [23:0]                  seen;
  logic [12:0]                  poll_period_ms;
  logic [9:0]                   current_direction_bit;
  logic [4:0]                   scan_channel;
  logic                         soft_reset_pulse;
  logic                         poll_mode;
  logic                         scan_valid;
  logic                         rd_seen;
  logic [23:0]                  exp_q[$];
  int                           n_mismatch;
  int                           checked;
  int                           cycles;
  int                           seed;
  logic [12:0]                  period_tab[16] = '{13'h0002, 13'h0004, 13'h0008,
    13'h0010, 13'h0020, 13'h0030, 13'h0040, 13'h0080, 13'h0100, 13'h0200,
    13'h0400, 13'h0800, 13'h1000, 13'h0008, 13'h0008, 13'h0008};

  switch_scan_config_regs #(.ms_cycles(4)) dut_u (
    .core_clk(core_clk), .srst(srst), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .soft_reset_pulse(soft_reset_pulse), .channel_monitor_en(channel_monitor_en),
    .current_direction_bit(current_direction_bit), .poll_period_ms(poll_period_ms),
    .poll_mode(poll_mode), .scan_valid(scan_valid), .scan_channel(scan_channel));

  reg_commander cmd_u (.core_clk(core_clk), .reg_req(reg_req));

  // 50 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  task automatic compare(input logic [23:0] got, input logic [23:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    // a read note never answered counts against the run
    if (exp_q.size() != 0) n_mismatch++;
    $display("mismatches %0d comparisons %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [5:0] a, input logic [23:0] d);
    cmd_u.access(1'b1, 1'b0, a, d);
  endtask

  // notes the expected read data, then issues the read
  task automatic rd(input logic [5:0] a, input logic [23:0] e);
    exp_q.push_back(e);
    cmd_u.access(1'b0, 1'b1, a, 24'($random(seed)));
  endtask

  task automatic look(input int n);
    repeat (n) @(posedge core_clk);
    @(negedge core_clk);
  endtask

  // read data checker and scan visit recorder
  always @(posedge core_clk) rd_seen <= reg_req.rd;
  always @(negedge core_clk) begin
    if (rd_seen === 1'b1) compare(reg_rdata, exp_q.pop_front());
    if (scan_valid === 1'b1) seen[scan_channel] = 1'b1;
  end

  // hang guard
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      test_done();
    end
  end

  initial begin
    seed = 21032;
    srst = 1'b1;
    seen = '0;
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    rd(switch_scan_pkg::ADDR_IN_ENABLE, 24'h00_0000);
    rd(switch_scan_pkg::ADDR_CUR_DIR, 24'h00_0000);
    rd(6'h3f, 24'h00_0000);
    // every poll code
    for (int c = 0; c < 16; c++) begin
      wr(switch_scan_pkg::ADDR_CONFIG, {19'h0_0000, 4'(c), 1'b0});
      look(1);
      compare(24'(poll_period_ms), 24'(period_tab[c]));
    end
    en = 24'($random(seed));
    wr(switch_scan_pkg::ADDR_IN_ENABLE, en);
    rd(switch_scan_pkg::ADDR_IN_ENABLE, en);
    look(0);
    compare(channel_monitor_en, en);
    seen = '0;
    wr(switch_scan_pkg::ADDR_CONFIG, 24'h00_0800);
    look(60);
    wr(switch_scan_pkg::ADDR_CONFIG, 24'h00_0000);
    look(2);
    compare(seen, en);
    dir = 24'($random(seed));
    wr(switch_scan_pkg::ADDR_CUR_DIR, dir);
    rd(switch_scan_pkg::ADDR_CUR_DIR, dir & 24'h00_03ff);
    look(0);
    compare(24'(current_direction_bit), dir & 24'h00_03ff);
    // polling: a whole 2 ms period of 8 cycles passes before one full sweep
    wr(switch_scan_pkg::ADDR_IN_ENABLE, 24'hff_ffff);
    seen = '0;
    wr(switch_scan_pkg::ADDR_CONFIG, 24'h00_0c00);
    rd(switch_scan_pkg::ADDR_CONFIG, 24'h00_0c00);
    look(0);
    compare(24'(poll_mode), 24'h00_0001);
    look(5);
    compare(seen, 24'h00_0000);
    look(30);
    compare(seen, 24'hff_ffff);
    wr(switch_scan_pkg::ADDR_CONFIG, 24'h00_0001);
    look(0);
    compare(24'(soft_reset_pulse), 24'h00_0001);
    look(1);
    compare(24'(soft_reset_pulse), 24'h00_0000);
    rd(switch_scan_pkg::ADDR_CONFIG, 24'h00_0000);
    rd(switch_scan_pkg::ADDR_IN_ENABLE, 24'h00_0000);
    rd(switch_scan_pkg::ADDR_CUR_DIR, 24'h00_0000);
    look(1);
    test_done();
  end
endmodule // testbench
